// ===== pkg/cpu_core_pkg.sv
// Shared constants and types for the CPU architectural state block.
// Assumes one clock domain; all users refer to items as cpu_core_pkg::name.
package cpu_core_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned IDX_W = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Address map of the 64-Kbyte space
    localparam logic [15:0] ADDR_IO_LAST = 16'h007f;
    localparam logic [15:0] ADDR_PROG_FIRST = 16'h8000;
    localparam logic [15:0] ADDR_VECTOR_FIRST = 16'hffc0;

    ////////////////////////////////////////////////////////////////////////////
    // Register bank placement
    localparam logic [15:0] GPR_BASE = 16'h0100;
    localparam int unsigned BANK_LSB = 8;
    localparam int unsigned BANK_W = 5;
    localparam int unsigned BANK_SHIFT = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] SP_RESET = 16'h0000;
    localparam logic [15:0] PS_RESET = 16'h0030;

    ////////////////////////////////////////////////////////////////////////////
    // Types
    typedef enum logic [2:0] {
        SEL_PC = 3'h0,
        SEL_ACC = 3'h1,
        SEL_TMP = 3'h2,
        SEL_INDEX = 3'h3,
        SEL_EXTRA = 3'h4,
        SEL_STACK = 3'h5,
        SEL_PSW = 3'h6
    } reg_sel_t;

    typedef enum logic [2:0] {
        OP_ADD = 3'h0,
        OP_ADDC = 3'h1,
        OP_SUB = 3'h2,
        OP_SUBC = 3'h3,
        OP_CMP = 3'h4,
        OP_SHL = 3'h5,
        OP_SHR = 3'h6,
        OP_PASS = 3'h7
    } alu_op_t;

    typedef enum logic [1:0] {
        REGION_IO = 2'h0,
        REGION_DATA = 2'h1,
        REGION_PROGRAM = 2'h2,
        REGION_VECTOR = 2'h3
    } region_t;

    // Layout of the condition code byte, bit 7 down to bit 0
    typedef struct packed {
        logic h;
        logic i;
        logic interrupt_level_high_bit;
        logic interrupt_level_low_bit;
        logic n;
        logic z;
        logic v;
        logic c;
    } ccr_t;

    typedef struct packed {
        logic [7:0] bank_pointer;
        ccr_t condition_code_byte;
    } psw_t;

    typedef struct packed {
        logic [15:0] program_counter;
        logic [15:0] acc;
        logic [15:0] tmp;
        logic [15:0] index_register;
        logic [15:0] extra_pointer;
        logic [15:0] stack_pointer;
        psw_t program_status_word;
    } core_regs_t;

    typedef struct packed {
        core_regs_t regs;
        logic [15:0] bank_base;
        region_t region;
    } core_state_t;

endpackage

// ===== src/alu_flags.sv
// Byte ALU: result and condition code update for one 8-bit operation.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
module alu_flags (
    // Operands
    input wire logic [7:0] i_a,
    input wire logic [7:0] i_b,
    input wire cpu_core_pkg::alu_op_t i_op,
    input wire cpu_core_pkg::ccr_t i_ccr,
    // Answer
    output logic [7:0] o_result,
    output logic o_write,
    output cpu_core_pkg::ccr_t o_ccr
);
    logic [8:0] wide;
    logic [4:0] nib;
    logic cin;
    logic is_sub;

    always_comb begin
        o_ccr = i_ccr;
        o_write = 1'b1;
        cin = 1'b0;
        is_sub = 1'b0;
        wide = 9'h000;
        nib = 5'h00;
        unique case (i_op)
            cpu_core_pkg::OP_ADD, cpu_core_pkg::OP_ADDC: begin
                cin = (i_op == cpu_core_pkg::OP_ADDC) ? i_ccr.c : 1'b0;
                wide = {1'b0, i_a} + {1'b0, i_b} + {8'h00, cin};
                nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]} + {4'h0, cin};
            end
            cpu_core_pkg::OP_SUB, cpu_core_pkg::OP_SUBC, cpu_core_pkg::OP_CMP: begin
                is_sub = 1'b1;
                cin = (i_op == cpu_core_pkg::OP_SUBC) ? i_ccr.c : 1'b0;
                wide = {1'b0, i_a} - {1'b0, i_b} - {8'h00, cin};
                nib = {1'b0, i_a[3:0]} - {1'b0, i_b[3:0]} - {4'h0, cin};
                o_write = (i_op != cpu_core_pkg::OP_CMP);
            end
            cpu_core_pkg::OP_SHL: begin
                wide = {i_a, i_ccr.c};
            end
            cpu_core_pkg::OP_SHR: begin
                wide = {i_a[0], i_ccr.c, i_a[7:1]};
            end
            cpu_core_pkg::OP_PASS: begin
                wide = {1'b0, i_a};
            end
        endcase
        o_result = wide[7:0];
        o_ccr.n = wide[7];
        o_ccr.z = (wide[7:0] == 8'h00);
        unique case (i_op)
            cpu_core_pkg::OP_SHL, cpu_core_pkg::OP_SHR: begin
                o_ccr.c = wide[8];
                o_ccr.v = 1'b0;
            end
            cpu_core_pkg::OP_PASS: begin
                o_ccr.v = 1'b0;
            end
            default: begin
                // Borrow shows as the ninth and fifth bit of the difference
                o_ccr.h = nib[4];
                o_ccr.c = wide[8];
                if (is_sub) begin
                    o_ccr.v = (i_a[7] != i_b[7]) && (wide[7] != i_a[7]);
                end else begin
                    o_ccr.v = (i_a[7] == i_b[7]) && (wide[7] != i_a[7]);
                end
            end
        endcase
    end
endmodule

// ===== src/cpu_status_flags_and_register_banks.sv
// CPU architectural state: dedicated 16-bit registers, status word,
// byte ALU flag update, interrupt gate, address map and bank addressing.
// Assumes a sequencer on the same clock drives all inputs.
`timescale 1ns/1ps
module cpu_status_flags_and_register_banks (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register write port
    input wire logic i_wr_en,
    input wire cpu_core_pkg::reg_sel_t i_wr_sel,
    input wire logic [15:0] i_wr_data,
    // Byte ALU request
    input wire logic i_alu_en,
    input wire cpu_core_pkg::alu_op_t i_alu_op,
    // Interrupt request
    input wire logic i_irq_req,
    input wire logic [1:0] i_irq_level,
    // Address classification and register bank lookup
    input wire logic [15:0] i_addr,
    input wire logic [2:0] i_gpr_idx,
    // Architectural state
    output cpu_core_pkg::core_regs_t o_regs,
    output cpu_core_pkg::region_t o_region,
    output logic [15:0] o_bank_base,
    output logic [15:0] o_gpr_addr,
    // Interrupt answer
    output logic o_irq_accept
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    cpu_core_pkg::core_state_t state;
    cpu_core_pkg::core_state_t next_state;

    logic [7:0] alu_result;
    logic alu_write;
    cpu_core_pkg::ccr_t alu_ccr;
    cpu_core_pkg::ccr_t cur_ccr;

    assign cur_ccr = state.regs.program_status_word.condition_code_byte;

    ////////////////////////////////////////////////////////////////////////////
    // Byte ALU on the low bytes of accumulator and temporary

    alu_flags u_alu (
        .i_a(state.regs.acc[7:0]),
        .i_b(state.regs.tmp[7:0]),
        .i_op(i_alu_op),
        .i_ccr(cur_ccr),
        .o_result(alu_result),
        .o_write(alu_write),
        .o_ccr(alu_ccr)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bank base from a status word value

    function automatic logic [15:0] bank_base_of(input cpu_core_pkg::psw_t psw);
        logic [cpu_core_pkg::BANK_W-1:0] bank;
        bank = psw.bank_pointer[cpu_core_pkg::BANK_W-1:0];
        bank_base_of = cpu_core_pkg::GPR_BASE
            + {8'h00, bank, 3'h0};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_state = state;
        // A register write takes precedence; a same-cycle ALU request is dropped
        if (i_wr_en) begin
            unique case (i_wr_sel)
                cpu_core_pkg::SEL_PC: next_state.regs.program_counter = i_wr_data;
                cpu_core_pkg::SEL_ACC: next_state.regs.acc = i_wr_data;
                cpu_core_pkg::SEL_TMP: next_state.regs.tmp = i_wr_data;
                cpu_core_pkg::SEL_INDEX: next_state.regs.index_register = i_wr_data;
                cpu_core_pkg::SEL_EXTRA: next_state.regs.extra_pointer = i_wr_data;
                cpu_core_pkg::SEL_STACK: next_state.regs.stack_pointer = i_wr_data;
                cpu_core_pkg::SEL_PSW: next_state.regs.program_status_word = i_wr_data;
                default: next_state.regs = state.regs;
            endcase
        end else if (i_alu_en) begin
            // High byte of the accumulator is left alone
            if (alu_write) begin
                next_state.regs.acc[7:0] = alu_result;
            end
            next_state.regs.program_status_word.condition_code_byte = alu_ccr;
        end
        next_state.bank_base = bank_base_of(next_state.regs.program_status_word);
        // Address map, lowest to highest
        if (i_addr <= cpu_core_pkg::ADDR_IO_LAST) begin
            next_state.region = cpu_core_pkg::REGION_IO;
        end else if (i_addr < cpu_core_pkg::ADDR_PROG_FIRST) begin
            next_state.region = cpu_core_pkg::REGION_DATA;
        end else if (i_addr < cpu_core_pkg::ADDR_VECTOR_FIRST) begin
            next_state.region = cpu_core_pkg::REGION_PROGRAM;
        end else begin
            next_state.region = cpu_core_pkg::REGION_VECTOR;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state.regs.program_counter <= cpu_core_pkg::PC_RESET;
            state.regs.acc <= 16'h0000;
            state.regs.tmp <= 16'h0000;
            state.regs.index_register <= 16'h0000;
            state.regs.extra_pointer <= 16'h0000;
            state.regs.stack_pointer <= cpu_core_pkg::SP_RESET;
            state.regs.program_status_word <= cpu_core_pkg::PS_RESET;
            state.bank_base <= cpu_core_pkg::GPR_BASE;
            state.region <= cpu_core_pkg::REGION_IO;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign o_regs = state.regs;
    assign o_region = state.region;
    assign o_bank_base = state.bank_base;
    // Index is live; the base behind it comes from a flop
    assign o_gpr_addr = state.bank_base + {13'h0000, i_gpr_idx};

    // Smaller level number ranks higher; level 3 is never above anything
    assign o_irq_accept = i_irq_req && cur_ccr.i
        && (i_irq_level < {cur_ccr.interrupt_level_high_bit,
                           cur_ccr.interrupt_level_low_bit});

endmodule

// ===== test/cpu_core_props.sv
// Port assertions for the status and bank block.
// Bound to the block top; one clock, synchronous active high reset.
`timescale 1ns/1ps
module cpu_core_props (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_wr_en,
    input wire cpu_core_pkg::reg_sel_t i_wr_sel,
    input wire logic [15:0] i_wr_data,
    input wire logic i_alu_en,
    input wire cpu_core_pkg::alu_op_t i_alu_op,
    input wire logic i_irq_req,
    input wire logic [1:0] i_irq_level,
    input wire logic [2:0] i_gpr_idx,
    input wire cpu_core_pkg::core_regs_t o_regs,
    input wire logic [15:0] o_bank_base,
    input wire logic [15:0] o_gpr_addr,
    input wire logic o_irq_accept
);
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    cpu_core_pkg::ccr_t cc;
    logic add_go;
    assign cc = o_regs.program_status_word.condition_code_byte;
    // A write in the same cycle drops the operation
    assign add_go = i_alu_en && !i_wr_en && i_alu_op == cpu_core_pkg::OP_ADD;
    ////////////////////////////////////////
    AST_WR_PC: assert property (i_wr_en && i_wr_sel == cpu_core_pkg::SEL_PC
        |=> o_regs.program_counter == $past(i_wr_data)) else $error("pc write lost");
    AST_RST_I: assert property ($fell(i_rst) |-> !cc.i && !o_irq_accept)
        else $error("enable not cleared");
    AST_IRQ: assert property (o_irq_accept == (i_irq_req && cc.i
        && i_irq_level < {cc.interrupt_level_high_bit, cc.interrupt_level_low_bit}))
        else $error("irq gate");
    AST_BANK: assert property (o_bank_base == cpu_core_pkg::GPR_BASE
        + {8'h00, o_regs.program_status_word.bank_pointer[4:0], 3'h0}) else $error("bank");
    AST_GPR: assert property (o_gpr_addr == o_bank_base + {13'h0000, i_gpr_idx})
        else $error("gpr addr");
    AST_ADD_C: assert property (add_go
        |=> {cc.c, o_regs.acc[7:0]} == $past(o_regs.acc[7:0]) + 9'h000 + $past(o_regs.tmp[7:0]))
        else $error("add carry");
    AST_NEG: assert property (add_go |=> cc.n == o_regs.acc[7]) else $error("neg flag");
    AST_ZERO: assert property (add_go |=> cc.z == (o_regs.acc[7:0] == 8'h00))
        else $error("zero flag");
    AST_ACC_HI: assert property (i_alu_en && !i_wr_en |=> $stable(o_regs.acc[15:8]))
        else $error("acc high");
endmodule

bind cpu_status_flags_and_register_banks cpu_core_props chk_i (.i_clk, .i_rst, .i_wr_en,
    .i_wr_sel, .i_wr_data, .i_alu_en, .i_alu_op, .i_irq_req, .i_irq_level, .i_gpr_idx,
    .o_regs, .o_bank_base, .o_gpr_addr, .o_irq_accept);

// ===== test/tb.sv
// Self-checking bench of the status and bank block.
// Inputs change at the falling edge; the checker is bound on its own.
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] cin;
        cpu_core_pkg::alu_op_t op;
        logic [7:0] res;
        logic [7:0] cc;
    } alu_row_t;
    localparam alu_row_t ROWS [9] = '{
        '{8'h80, 8'h80, 8'h00, cpu_core_pkg::OP_ADD, 8'h00, 8'h07},
        '{8'h7f, 8'h00, 8'h01, cpu_core_pkg::OP_ADDC, 8'h80, 8'h8a},
        '{8'h00, 8'h01, 8'h00, cpu_core_pkg::OP_SUB, 8'hff, 8'h89},
        '{8'h05, 8'h05, 8'h01, cpu_core_pkg::OP_SUBC, 8'hff, 8'h89},
        '{8'h80, 8'h01, 8'h00, cpu_core_pkg::OP_CMP, 8'h80, 8'h82},
        '{8'h81, 8'h00, 8'h80, cpu_core_pkg::OP_SHL, 8'h02, 8'h81},
        '{8'h03, 8'h00, 8'h00, cpu_core_pkg::OP_SHR, 8'h01, 8'h01},
        '{8'h00, 8'h33, 8'h83, cpu_core_pkg::OP_PASS, 8'h00, 8'h85},
        '{8'h01, 8'h01, 8'h01, cpu_core_pkg::OP_ADD, 8'h02, 8'h00}};
    localparam logic [15:0] ADDRS [6] = '{16'h007f, 16'h0080, 16'h7fff,
        16'h8000, 16'hffbf, 16'hffc0};
    localparam logic [1:0] AREAS [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_wr_en = 1'b0;
    cpu_core_pkg::reg_sel_t i_wr_sel = cpu_core_pkg::SEL_PC;
    logic [15:0] i_wr_data = 16'h0000;
    logic i_alu_en = 1'b0;
    cpu_core_pkg::alu_op_t i_alu_op = cpu_core_pkg::OP_ADD;
    logic i_irq_req = 1'b0;
    logic [1:0] i_irq_level = 2'h0;
    logic [15:0] i_addr = 16'h0000;
    logic [2:0] i_gpr_idx = 3'h0;
    cpu_core_pkg::core_regs_t o_regs;
    cpu_core_pkg::region_t o_region;
    logic [15:0] o_bank_base;
    logic [15:0] o_gpr_addr;
    logic o_irq_accept;
    logic [15:0] psw;
    int err_total = 0;
    int cmp_count = 0;
    assign psw = o_regs.program_status_word;
    always #4 i_clk = ~i_clk;
    cpu_status_flags_and_register_banks dut (.i_clk, .i_rst, .i_wr_en, .i_wr_sel, .i_wr_data,
        .i_alu_en, .i_alu_op, .i_irq_req, .i_irq_level, .i_addr, .i_gpr_idx,
        .o_regs, .o_region, .o_bank_base, .o_gpr_addr, .o_irq_accept);
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input cpu_core_pkg::reg_sel_t s, input logic [15:0] d);
        @(negedge i_clk);
        i_wr_en = 1'b1;
        i_wr_sel = s;
        i_wr_data = d;
        @(negedge i_clk);
        i_wr_en = 1'b0;
    endtask
    task automatic alu(input cpu_core_pkg::alu_op_t op);
        @(negedge i_clk);
        i_alu_en = 1'b1;
        i_alu_op = op;
        @(negedge i_clk);
        i_alu_en = 1'b0;
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (3) @(negedge i_clk);
        i_rst = 1'b0;
        foreach (ROWS[k]) begin
            wr(cpu_core_pkg::SEL_PSW, {8'h00, ROWS[k].cin});
            wr(cpu_core_pkg::SEL_ACC, {8'ha5, ROWS[k].a});
            wr(cpu_core_pkg::SEL_TMP, {8'h5a, ROWS[k].b});
            alu(ROWS[k].op);
            chk("acc", {8'ha5, ROWS[k].res}, o_regs.acc);
            chk("ccr", {8'h00, ROWS[k].cc}, psw);
        end
        $display("alu rows done");
        foreach (ADDRS[k]) begin
            @(negedge i_clk);
            i_addr = ADDRS[k];
            @(negedge i_clk);
            chk("region", {14'h0000, AREAS[k]}, {14'h0000, o_region});
        end
        for (int s = 0; s < 6; s++) wr(cpu_core_pkg::reg_sel_t'(s), 16'hc3a0 + 16'(s));
        for (int s = 0; s < 6; s++) begin
            chk("reg", 16'hc3a0 + 16'(s), o_regs[111 - 16 * s -: 16]);
        end
        // Top three pointer bits are stored but must not move the bank
        wr(cpu_core_pkg::SEL_PSW, 16'hff00);
        i_gpr_idx = 3'h7;
        #1 chk("gpr", cpu_core_pkg::GPR_BASE + 16'h00ff, o_gpr_addr);
        for (int m = 0; m < 64; m++) begin
            wr(cpu_core_pkg::SEL_PSW, {9'h000, m[4:2], 4'h0});
            i_irq_req = m[5];
            i_irq_level = m[1:0];
            #1 chk("irq", {15'h0000, m[5] && m[4] && m[1:0] < m[3:2]},
                {15'h0000, o_irq_accept});
        end
        $display("map, bank and gate done");
        wr(cpu_core_pkg::SEL_PSW, 16'h0940);
        @(negedge i_clk);
        i_rst = 1'b1;
        @(negedge i_clk);
        i_rst = 1'b0;
        chk("psw", cpu_core_pkg::PS_RESET, psw);
        chk("base", cpu_core_pkg::GPR_BASE, o_bank_base);
        $display("reset done");
        // Write beats a same-cycle operation; select code 7 writes nothing
        @(negedge i_clk);
        i_wr_en = 1'b1;
        i_wr_sel = cpu_core_pkg::SEL_ACC;
        i_wr_data = 16'h00ff;
        i_alu_en = 1'b1;
        i_alu_op = cpu_core_pkg::OP_SHL;
        @(negedge i_clk);
        i_alu_en = 1'b0;
        i_wr_sel = cpu_core_pkg::reg_sel_t'(3'h7);
        i_wr_data = 16'h1234;
        @(negedge i_clk);
        i_wr_en = 1'b0;
        chk("acc", 16'h00ff, o_regs.acc);
        chk("psw", cpu_core_pkg::PS_RESET, psw);
        $display("priority done");
        close_out();
    end
    initial begin
        #20000;
        err_total++;
        close_out();
    end
endmodule
